// >>> shared/pphs_pkg.sv
`default_nettype none

package pphs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int IRQ_PULSE_NS = 100;
  localparam int IRQ_PULSE_CYC_I = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] IRQ_PULSE_CYC = 4'(IRQ_PULSE_CYC_I);

  // ----------------------------------------------------------------
  // Processor address decode
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int REGION_HI = 23;
  localparam int REGION_LO = 20;
  localparam logic [3:0] REGION_HOST = 4'hF;
  localparam logic [3:0] REGION_IO = 4'h8;
  localparam logic [3:0] REGION_RAM = 4'hC;
  localparam logic [3:0] REGION_BOOT = 4'h0;
  localparam logic [7:0] HOST_PAGE = 8'hFF;
  localparam logic [23:0] HANDSHAKE_ADDR = 24'hFF_F000;

  // ----------------------------------------------------------------
  // AHB-Lite register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL_OFS = 12'h000;
  localparam logic [11:0] REG_STATUS_OFS = 12'h004;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic [1:0] HRESP_OKAY = 2'b00;

  // Control register fields
  localparam int CTRL_TRI_BIT = 0;
  localparam int CTRL_SELECT_A_BIT = 1;
  localparam int CTRL_LED_IO_BIT = 2;
  localparam int CTRL_LED_BOOT_BIT = 3;
  localparam int CTRL_BIDIR_BIT = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Status register fields
  localparam int STAT_ACK_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_WRITE_BIT = 2;
  localparam int STAT_STROBE_BIT = 3;
  localparam int STAT_IRQ_BIT = 4;
  localparam int STAT_CNT_LO = 16;
  localparam int XFER_CNT_W = 16;

  // ----------------------------------------------------------------
  // Handshake sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PPHS_IDLE,
    PPHS_STALL,
    PPHS_DONE
  } pphs_hs_state_t;

endpackage

`default_nettype wire

// >>> src/pphs_strobe_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pphs_strobe_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic strobe_in,
  output logic level,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } pphs_sync_state_t;

  pphs_sync_state_t state_q;
  pphs_sync_state_t state_d;

  // First stage feeds only the second stage
  always_comb begin
    state_d = state_q;
    state_d.s1 = strobe_in;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= 3'b111;
    end else begin
      state_q <= state_d;
    end
  end

  assign level = state_q.s2;
  assign rise = state_q.s2 & ~state_q.s3;
  assign fall = ~state_q.s2 & state_q.s3;

endmodule

`default_nettype wire

// >>> src/pphs_host_port.sv
// Contract
// - Host region found from processor strobe plus address bits 23..12.
// - Five decode outputs plus ready, host request interrupt, transceiver enable.
// - Tristate control floats the interrupt and ready outputs.
// - Select high makes the io and boot decodes drive the LED.
// - Eight-bit both ways when bidirectional, else 8-bit in, 4-bit out.
// - Status 7..4 carry data 3..0, status 3 carries acknowledge.
// - Host strobe falling pulses the request interrupt; processor uses first only.
// - Handshake read asserts acknowledge, error low, ready high to stall.
// - Host strobe rising drops ready, releasing the stalled access.
// - Inbound words move as four bytes, least significant first.
// - Handshake write also asserts acknowledge, error low, ready high.
// - Bootload skips bytes three and four of the first word.
// - Range FFF000 to FFFFFF steers accesses to the host interface.
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pphs_host_port (
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  // Processor parallel bus
  input wire logic proc_strobe_n,
  input wire logic [23:0] proc_addr,
  input wire logic proc_rw,
  input wire logic [7:0] proc_data_i,
  output logic [7:0] proc_data_o,
  output logic proc_data_oe_n,
  output logic ready_o,
  output logic ready_oe_n,
  output logic host_request_interrupt_o,
  output logic host_request_interrupt_oe_n,
  output logic user_io_read_decode,
  output logic user_io_write_decode,
  output logic user_io_decode,
  output logic user_ram_decode,
  output logic boot_decode,
  output logic xcvr_en_n,
  // Host printer port
  input wire logic host_side_strobe,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_n,
  output logic [3:0] host_status_nibble,
  output logic interface_acknowledge,
  output logic host_error_n
);

  typedef struct packed {
    pphs_pkg::pphs_hs_state_t hs;
    logic hs_wr;
    logic ready;
    logic ack;
    logic irq;
    logic [3:0] irq_cnt;
    logic [pphs_pkg::CTRL_W-1:0] ctrl;
    logic ap_valid;
    logic ap_write;
    logic [11:0] ap_ofs;
    logic [31:0] rdata;
    logic ior;
    logic iow;
    logic io;
    logic ram;
    logic boot;
    logic en_n;
    logic [7:0] pdata;
    logic pdata_oe_n;
    logic [7:0] hdata;
    logic hdata_oe_n;
    logic [3:0] nibble;
    logic [pphs_pkg::XFER_CNT_W-1:0] xfer_cnt;
    logic hrdy;
    logic tri_en;
  } pphs_top_state_t;

  pphs_top_state_t state_q;
  pphs_top_state_t state_d;

  logic strobe_level;
  logic strobe_rise;
  logic strobe_fall;
  logic region_hit;
  logic hs_hit;
  logic [3:0] region;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // Host strobe crossing
  // ----------------------------------------------------------------
  pphs_strobe_sync u_strobe_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .strobe_in(host_side_strobe),
    .level(strobe_level),
    .rise(strobe_rise),
    .fall(strobe_fall)
  );

  // ----------------------------------------------------------------
  // Decode and status
  // ----------------------------------------------------------------
  assign region = proc_addr[pphs_pkg::REGION_HI:pphs_pkg::REGION_LO];
  assign region_hit = !proc_strobe_n && region == pphs_pkg::REGION_HOST
                      && proc_addr[19:12] == pphs_pkg::HOST_PAGE;
  assign hs_hit = region_hit && proc_addr == pphs_pkg::HANDSHAKE_ADDR;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[pphs_pkg::STAT_ACK_BIT] = state_q.ack;
    status_word[pphs_pkg::STAT_READY_BIT] = state_q.ready;
    status_word[pphs_pkg::STAT_WRITE_BIT] = state_q.hs_wr;
    status_word[pphs_pkg::STAT_STROBE_BIT] = strobe_level;
    status_word[pphs_pkg::STAT_IRQ_BIT] = state_q.irq;
    status_word[pphs_pkg::STAT_CNT_LO +: pphs_pkg::XFER_CNT_W] = state_q.xfer_cnt;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // AHB address phase; zero wait states so read data is ready next cycle
    state_d.ap_valid = hsel && htrans[1] && hready;
    state_d.ap_write = hwrite && hsize == pphs_pkg::HSIZE_WORD;
    state_d.ap_ofs = haddr[11:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[11:0])
        pphs_pkg::REG_CTRL_OFS: state_d.rdata = {27'h000_0000, state_q.ctrl};
        pphs_pkg::REG_STATUS_OFS: state_d.rdata = status_word;
        default: state_d.rdata = 32'h0000_0000;
      endcase
    end
    if (state_q.ap_valid && state_q.ap_write && state_q.ap_ofs == pphs_pkg::REG_CTRL_OFS) begin
      state_d.ctrl = hwdata[pphs_pkg::CTRL_W-1:0];
    end
    state_d.hrdy = 1'b1;
    // One cycle behind the control bit, so a write settles before pins move
    state_d.tri_en = state_q.ctrl[pphs_pkg::CTRL_TRI_BIT];

    // Address decodes; select_a mode hands io and boot over to the LED
    state_d.ior = !proc_strobe_n && region == pphs_pkg::REGION_IO && proc_rw;
    state_d.iow = !proc_strobe_n && region == pphs_pkg::REGION_IO && !proc_rw;
    state_d.ram = !proc_strobe_n && region == pphs_pkg::REGION_RAM;
    state_d.en_n = !region_hit;
    if (state_q.ctrl[pphs_pkg::CTRL_SELECT_A_BIT]) begin
      state_d.io = state_q.ctrl[pphs_pkg::CTRL_LED_IO_BIT];
      state_d.boot = state_q.ctrl[pphs_pkg::CTRL_LED_BOOT_BIT];
    end else begin
      state_d.io = !proc_strobe_n && region == pphs_pkg::REGION_IO;
      state_d.boot = !proc_strobe_n && region == pphs_pkg::REGION_BOOT;
    end

    // Every falling host strobe pulses the request; the processor filters repeats
    if (strobe_fall) begin
      state_d.irq = 1'b1;
      state_d.irq_cnt = pphs_pkg::IRQ_PULSE_CYC - 4'h1;
    end else if (state_q.irq_cnt != 4'h0) begin
      state_d.irq_cnt = state_q.irq_cnt - 4'h1;
    end else begin
      state_d.irq = 1'b0;
    end

    // Handshake sequencer
    unique case (state_q.hs)
      pphs_pkg::PPHS_IDLE: begin
        if (hs_hit) begin
          state_d.hs = pphs_pkg::PPHS_STALL;
          state_d.hs_wr = !proc_rw;
          state_d.ready = 1'b1;
          state_d.ack = 1'b1;
        end
      end
      pphs_pkg::PPHS_STALL: begin
        if (strobe_rise) begin
          // Edge is a one-cycle pulse, so one access is freed per edge
          state_d.hs = pphs_pkg::PPHS_DONE;
          state_d.ready = 1'b0;
          state_d.ack = 1'b0;
          // No grouping by four, so skipped boot bytes cause no slip
          state_d.xfer_cnt = state_q.xfer_cnt + 16'h0001;
        end
      end
      pphs_pkg::PPHS_DONE: begin
        // Wait for the processor to end its cycle before a new stall
        if (!hs_hit) begin
          state_d.hs = pphs_pkg::PPHS_IDLE;
          state_d.hs_wr = 1'b0;
        end
      end
    endcase

    // Data paths during a stall
    state_d.pdata_oe_n = !(state_d.hs == pphs_pkg::PPHS_STALL && !state_d.hs_wr);
    // Byte frozen once the pin strobe rises: the host may move its data lines
    // with the rise, while the synchronised edge frees the access cycles later
    if (!state_d.pdata_oe_n && !host_side_strobe) begin
      state_d.pdata = host_data_i;
    end
    if (state_d.hs == pphs_pkg::PPHS_STALL && state_d.hs_wr) begin
      state_d.nibble = proc_data_i[3:0];
      state_d.hdata = proc_data_i;
      state_d.hdata_oe_n = !state_q.ctrl[pphs_pkg::CTRL_BIDIR_BIT];
    end else begin
      state_d.hdata_oe_n = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
      state_q.hs <= pphs_pkg::PPHS_IDLE;
      state_q.ctrl <= pphs_pkg::CTRL_RESET;
      state_q.en_n <= 1'b1;
      state_q.pdata_oe_n <= 1'b1;
      state_q.hdata_oe_n <= 1'b1;
      state_q.tri_en <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops except the constant hresp
  // ----------------------------------------------------------------
  assign hreadyout = state_q.hrdy;
  assign hrdata = state_q.rdata;
  assign hresp = pphs_pkg::HRESP_OKAY;
  assign proc_data_o = state_q.pdata;
  assign proc_data_oe_n = state_q.pdata_oe_n;
  assign ready_o = state_q.ready;
  assign ready_oe_n = state_q.tri_en;
  assign host_request_interrupt_o = state_q.irq;
  assign host_request_interrupt_oe_n = state_q.tri_en;
  assign user_io_read_decode = state_q.ior;
  assign user_io_write_decode = state_q.iow;
  assign user_io_decode = state_q.io;
  assign user_ram_decode = state_q.ram;
  assign boot_decode = state_q.boot;
  assign xcvr_en_n = state_q.en_n;
  assign host_data_o = state_q.hdata;
  assign host_data_oe_n = state_q.hdata_oe_n;
  assign host_status_nibble = state_q.nibble;
  assign interface_acknowledge = state_q.ack;
  assign host_error_n = !state_q.ack;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_stall_ready_high: assert property (
    (state_q.hs == pphs_pkg::PPHS_IDLE && hs_hit) |=> (ready_o && interface_acknowledge
      && !host_error_n)
  ) else $error("stall did not raise ready and acknowledge");

  a_release_on_rise: assert property (
    (state_q.hs == pphs_pkg::PPHS_STALL && strobe_rise) |=> (!ready_o
      && state_q.hs == pphs_pkg::PPHS_DONE)
  ) else $error("rising strobe did not release ready");

  a_stall_holds: assert property (
    (state_q.hs == pphs_pkg::PPHS_STALL && !strobe_rise) |=> ready_o
  ) else $error("ready dropped without a strobe edge");

  a_one_release_edge: assert property (
    (state_q.hs == pphs_pkg::PPHS_DONE) |=> state_q.hs != pphs_pkg::PPHS_STALL
  ) else $error("second access freed by one edge");

  a_irq_pulse_width: assert property (
    strobe_fall |=> host_request_interrupt_o [*5] ##1 !host_request_interrupt_o
  ) else $error("request pulse has wrong width");

  a_tri_floats: assert property (
    state_q.ctrl[pphs_pkg::CTRL_TRI_BIT] |=> (ready_oe_n && host_request_interrupt_oe_n)
  ) else $error("tristate control did not float outputs");

  a_host_region_en: assert property (
    region_hit |=> !xcvr_en_n
  ) else $error("host region did not enable transceivers");

  a_led_select_a: assert property (
    state_q.ctrl[pphs_pkg::CTRL_SELECT_A_BIT] |=> (user_io_decode
      == $past(state_q.ctrl[pphs_pkg::CTRL_LED_IO_BIT]))
  ) else $error("select did not steer the LED");

  a_ior_decode: assert property (
    (!proc_strobe_n && region == pphs_pkg::REGION_IO && proc_rw) |=> user_io_read_decode
  ) else $error("io read decode missing");

  a_ack_idle: assert property (
    (state_q.hs == pphs_pkg::PPHS_IDLE) |-> (!interface_acknowledge && host_error_n)
  ) else $error("acknowledge left high when idle");

  a_nibble_carry: assert property (
    (state_q.hs == pphs_pkg::PPHS_STALL && state_q.hs_wr && !strobe_rise)
      |=> host_status_nibble == $past(proc_data_i[3:0])
  ) else $error("status nibble does not carry data");

  a_read_drive: assert property (
    (state_q.hs == pphs_pkg::PPHS_STALL && !state_q.hs_wr) |-> !proc_data_oe_n
  ) else $error("read stall does not drive the host byte");

  a_byte_frozen: assert property (
    (!proc_data_oe_n && host_side_strobe) |=> proc_data_o == $past(proc_data_o)
  ) else $error("host byte changed after the strobe rose");

  a_bidir_drive: assert property (
    (state_q.hs == pphs_pkg::PPHS_STALL && state_q.hs_wr)
      |-> host_data_oe_n == !$past(state_q.ctrl[pphs_pkg::CTRL_BIDIR_BIT])
  ) else $error("host data drive does not follow the port mode");

  a_count_step: assert property (
    (state_q.hs == pphs_pkg::PPHS_STALL && strobe_rise)
      |=> state_q.xfer_cnt == $past(state_q.xfer_cnt) + 16'h0001
  ) else $error("handshake count did not step once");

  c_read_handshake: cover property (
    (state_q.hs == pphs_pkg::PPHS_STALL && !state_q.hs_wr) ##[1:100] !ready_o
  );
  c_write_handshake: cover property (
    (state_q.hs == pphs_pkg::PPHS_STALL && state_q.hs_wr) ##[1:100] !ready_o
  );
  c_select_a_led: cover property (state_q.ctrl[pphs_pkg::CTRL_SELECT_A_BIT] && user_io_decode);
  c_bidir_write: cover property (state_q.hs == pphs_pkg::PPHS_STALL && !host_data_oe_n);

endmodule

`default_nettype wire

// >>> verification/pphs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pphs_host_model (
  input wire logic mclk,
  output logic host_side_strobe,
  output wire logic [7:0] host_data_i,
  input wire logic [7:0] host_data_o,
  input wire logic host_data_oe_n,
  input wire logic [3:0] host_status_nibble,
  input wire logic interface_acknowledge
);
  logic [7:0] drv_q = 8'h00;

  // The wire shows the device's byte while it drives the port
  assign host_data_i = (host_data_oe_n === 1'b0) ? host_data_o : drv_q;
  initial host_side_strobe = 1'b1;

  task automatic put_byte(input logic [7:0] b);
    @(posedge mclk);
    drv_q <= b;
    @(posedge mclk);
    host_side_strobe <= 1'b0;
  endtask

  // Data lines move with the rise, so a late capture of the byte is caught
  task automatic raise();
    @(posedge mclk);
    host_side_strobe <= 1'b1;
    drv_q <= ~drv_q;
  endtask

  task automatic wait_ack();
    for (int n = 0; n < 40 && interface_acknowledge !== 1'b1; n++) begin
      @(posedge mclk);
    end
  endtask

  task automatic recv(input bit bidir, output logic [7:0] v);
    @(posedge mclk);
    host_side_strobe <= 1'b0;
    repeat (2) @(posedge mclk);
    v = bidir ? host_data_i : {4'h0, host_status_nibble};
    raise();
  endtask
endmodule

`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  logic proc_strobe_n = 1'b1;
  logic proc_rw = 1'b1;
  logic [23:0] proc_addr = 24'h30_0000;
  logic [7:0] proc_data_i = '0;
  wire logic hreadyout, proc_data_oe_n, ready_o, ready_oe_n, host_request_interrupt_o;
  wire logic host_request_interrupt_oe_n, user_io_read_decode, user_io_write_decode;
  wire logic user_io_decode, user_ram_decode, boot_decode, xcvr_en_n, host_side_strobe;
  wire logic host_data_oe_n, interface_acknowledge, host_error_n;
  wire logic [31:0] hrdata;
  wire logic [1:0] hresp;
  wire logic [7:0] proc_data_o, host_data_i, host_data_o;
  wire logic [3:0] host_status_nibble;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int irq_run = 0;
  int irq_w = 0;
  int hs_n = 0;
  logic [31:0] r, w, got;
  logic [7:0] q[$];
  logic [23:0] a;
  localparam logic [23:0] AT [6] = '{24'h8A_0000, 24'h85_0000, 24'hC1_0000,
                                     24'h01_0000, 24'hFF_F100, 24'hEF_F000};
  localparam logic [23:0] HS = pphs_pkg::HANDSHAKE_ADDR;

  pphs_host_port pphs_host_port_i (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .proc_strobe_n, .proc_addr,
    .proc_rw, .proc_data_i, .proc_data_o, .proc_data_oe_n, .ready_o, .ready_oe_n,
    .host_request_interrupt_o, .host_request_interrupt_oe_n, .user_io_read_decode,
    .user_io_write_decode, .user_io_decode, .user_ram_decode, .boot_decode, .xcvr_en_n,
    .host_side_strobe, .host_data_i, .host_data_o, .host_data_oe_n, .host_status_nibble,
    .interface_acknowledge, .host_error_n);

  pphs_host_model pphs_host_model_i (.mclk, .host_side_strobe, .host_data_i, .host_data_o,
    .host_data_oe_n, .host_status_nibble, .interface_acknowledge);

  always #10 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc++;
    if (host_request_interrupt_o === 1'b1) begin
      irq_run++;
    end else if (irq_run != 0) begin
      irq_w = irq_run;
      irq_run = 0;
    end
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Bus and handshake tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= pphs_pkg::HSIZE_WORD;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic proc(input logic [23:0] ad, input logic rw, input logic [7:0] d);
    @(posedge mclk);
    proc_strobe_n <= 1'b0;
    proc_addr <= ad;
    proc_rw <= rw;
    proc_data_i <= d;
  endtask

  task automatic release_chk();
    for (int n = 0; n < 40 && ready_o !== 1'b0; n++) @(posedge mclk);
    chk(ready_o, 1'b0);
    chk({interface_acknowledge, host_error_n}, 2'b01);
    hs_n++;
    @(posedge mclk);
    proc_strobe_n <= 1'b1;
    proc_addr <= 24'h30_0000;
  endtask

  task automatic h2p(input logic [7:0] b);
    pphs_host_model_i.put_byte(b);
    proc(HS, 1'b1, 8'h00);
    pphs_host_model_i.wait_ack();
    chk({ready_o, host_error_n, proc_data_oe_n}, 3'b100);
    q.push_back(proc_data_o);
    pphs_host_model_i.raise();
    release_chk();
    chk(proc_data_o, b);
  endtask

  task automatic p2h(input bit bidir, input logic [31:0] wv);
    logic [7:0] v;
    logic [31:0] acc;
    acc = '0;
    for (int i = 0; i < (bidir ? 4 : 8); i++) begin
      proc(HS, 1'b0, bidir ? wv[8*i +: 8] : {4'($urandom), wv[4*i +: 4]});
      pphs_host_model_i.wait_ack();
      chk({ready_o, host_error_n, interface_acknowledge}, 3'b101);
      chk(host_data_oe_n, !bidir);
      pphs_host_model_i.recv(bidir, v);
      if (bidir) acc[8*i +: 8] = v;
      else acc[4*i +: 4] = v[3:0];
      release_chk();
    end
    chk(acc, wv);
  endtask

  task automatic end_sim();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h834e));
    repeat (2) @(posedge mclk);
    chk({hreadyout, xcvr_en_n, ready_oe_n, host_request_interrupt_oe_n}, 4'b0111);
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    w = 32'($urandom) & 32'h0000_001F;
    ahb(1'b1, 32'(pphs_pkg::REG_CTRL_OFS), w);
    ahb(1'b0, 32'(pphs_pkg::REG_CTRL_OFS), 32'h0000_0000);
    chk(r, w);
    chk(hresp, pphs_pkg::HRESP_OKAY);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    ahb(1'b1, 32'(pphs_pkg::REG_CTRL_OFS), 32'h0000_0000);
    for (int k = 0; k < 6; k++) begin
      a = AT[k] | 24'($urandom & 32'h0000_07FF);
      proc(a, k[0], 8'($urandom));
      repeat (2) @(posedge mclk);
      chk({user_io_read_decode, user_io_write_decode, user_io_decode, user_ram_decode,
           boot_decode, !xcvr_en_n}, {a[23:20] == 4'h8 && k[0], a[23:20] == 4'h8 && !k[0],
           a[23:20] == 4'h8, a[23:20] == 4'hC, a[23:20] == 4'h0,
           a[23:12] == 12'hFFF});
      @(posedge mclk);
      proc_strobe_n <= 1'b1;
      repeat (2) @(posedge mclk);
      chk({user_io_decode, user_ram_decode, boot_decode, xcvr_en_n}, 4'b0001);
    end
    ahb(1'b1, 32'(pphs_pkg::REG_CTRL_OFS), 32'h0000_000E);
    repeat (3) @(posedge mclk);
    chk({user_io_decode, boot_decode}, 2'b11);
    ahb(1'b1, 32'(pphs_pkg::REG_CTRL_OFS), 32'h0000_0001);
    repeat (3) @(posedge mclk);
    chk({ready_oe_n, host_request_interrupt_oe_n, user_io_decode}, 3'b110);
    ahb(1'b1, 32'(pphs_pkg::REG_CTRL_OFS), 32'h0000_0000);
    repeat (3) @(posedge mclk);
    chk({ready_oe_n, host_request_interrupt_oe_n}, 2'b00);
    w = $urandom;
    for (int i = 0; i < 4; i++) begin
      h2p(w[8*i +: 8]);
      repeat (4) @(posedge mclk);
      chk(32'(irq_w), 32'(pphs_pkg::IRQ_PULSE_CYC));
    end
    got = {q[3], q[2], q[1], q[0]};
    chk(got, w);
    // A strobe rise with no stalled access must not be remembered
    pphs_host_model_i.put_byte(8'h5A);
    pphs_host_model_i.raise();
    repeat (6) @(posedge mclk);
    proc(HS, 1'b1, 8'h00);
    pphs_host_model_i.wait_ack();
    repeat (8) @(posedge mclk);
    chk(ready_o, 1'b1);
    pphs_host_model_i.put_byte(8'hA5);
    pphs_host_model_i.raise();
    release_chk();
    chk(proc_data_o, 32'h0000_00A5);
    p2h(1'b0, $urandom);
    ahb(1'b1, 32'(pphs_pkg::REG_CTRL_OFS), 32'h0000_0010);
    p2h(1'b1, $urandom);
    repeat (10) @(posedge mclk);
    ahb(1'b0, 32'(pphs_pkg::REG_STATUS_OFS), 32'h0000_0000);
    chk({r[31:16], 11'h000, r[4:0]}, {16'(hs_n), 11'h000, 5'b01000});
    end_sim();
  end
endmodule

`default_nettype wire
